// ---- serial_port_spi_clock_stop.sv ----
// Overview of operation
// R1: As slave, the rate clock runs at a quarter CPU rate: source and divider one.
// R2: The rate clock source select is always one, choosing the CPU clock.
// R3: Master bit clock period is (1 + divider) times four CPU periods.
// R4: High phase is (d/2+1)*4P for even divider, (d+1)/2*4P otherwise. For divider zero the code gives (d+1)/2*4P.
// R5: Low phase is (d/2)*4P for even divider, (d+1)/2*4P otherwise. For divider zero the code gives (d+1)/2*4P.
// R6: Both sync polarity bits are one; master select output is active low.
// R7: As slave, the active-low selects on both sync pins are inverted internally.
// R8: Master: transmit clock and sync modes one, receive clock and sync modes zero.
// R9: Slave: all four clock and sync direction mode bits are zero.
// R10: Select goes low before the first clock edge; transfer starts on rising edge.
// R11: Data is launched after a rising clock edge and sampled on a rising edge.
// R12: Select falls one period before first falling edge; data one low phase later.
// R13: Master holds select low for one high phase after the last rising edge.
// R14: Master releases its data pin after the final bit, after a rising edge.
// R15: Idle master holds clock high and select high; toggles only for word bits.
`timescale 1ns/1ns
`include "serial_port_spi_clock_stop_map.svh"

module serial_port_spi_clock_stop
    import serial_port_spi_clock_stop_pkg::*;
#(
    parameter int WORD_MAX = 32                     // Widest word served.
) (
    input  wire logic                ref_clk,              // System clock.
    input  wire logic                rstn,                 // Synchronous reset, low.
    input  wire cfg_t                cfg,                  // Port configuration.
    output logic                     cfg_unsupported,      // Mode other than 11b/idle high.
    output mode_t                    mode,                 // Applied mode bits.
    input  wire logic [WORD_MAX-1:0] tx_word,              // Word to send.
    input  wire logic                tx_valid,             // Word offered.
    output logic                     tx_ready,             // Word taken this cycle.
    output logic [WORD_MAX-1:0]      rx_word,              // Word received.
    output logic                     rx_valid,             // One-cycle receive pulse.
    output logic                     busy,                 // Master transfer running.
    input  wire logic                transmit_bit_clock_i, // Bit clock pin level.
    output logic                     transmit_bit_clock_o, // Bit clock drive.
    output logic                     transmit_bit_clock_oe,// Bit clock enable.
    input  wire logic                transmit_frame_sync_i,// Select pin level.
    output logic                     transmit_frame_sync_o,// Select drive.
    output logic                     transmit_frame_sync_oe,// Select enable.
    input  wire logic                receive_frame_sync_i, // Receive select pin.
    output logic                     serial_data_out,      // Data drive.
    output logic                     serial_data_out_oe,   // Data enable.
    input  wire logic                serial_data_in        // Data pin.
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (WORD_MAX < 2 || WORD_MAX > 64) begin : g_bad_width
        $error("WORD_MAX must lie between 2 and 64");
    end

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [`PIN_COUNT-1:0] s1_reg, s2_reg, s3_reg, stable_reg, stable_d_reg;
    logic [`PIN_COUNT-1:0] pins, stable_next;

    // A pin change counts once the second and third stages agree.
    always_comb begin
        pins        = {serial_data_in, receive_frame_sync_i,
                       transmit_frame_sync_i, transmit_bit_clock_i};
        stable_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & stable_reg);
    end

    // Synchroniser registers; reset reads clock and both selects high, data low.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s1_reg       <= 4'h7;
            s2_reg       <= 4'h7;
            s3_reg       <= 4'h7;
            stable_reg   <= 4'h7;
            stable_d_reg <= 4'h7;
        end else begin
            s1_reg       <= pins;
            s2_reg       <= s1_reg;
            s3_reg       <= s2_reg;
            stable_reg   <= stable_next;
            stable_d_reg <= stable_reg;
        end
    end

    // ------------------------------------------------------------------
    // Bit clock phase lengths
    // ------------------------------------------------------------------
    // Length of one phase in ref_clk cycles, computed in half rate units.
    function automatic logic [9:0] phase_len(input logic [7:0] d, input logic high);
        logic [8:0] halves;
        halves = 9'h000;
        if (d == 8'h00 || d[0]) begin
            halves = {1'b0, d} + 9'h001;                              // R4 R5
        end else if (high) begin
            halves = {1'b0, d} + 9'h002;                              // R4
        end else begin
            halves = {1'b0, d};                                       // R5
        end
        return 10'((int'(halves) * `RATE_UNIT_CYC) / 2);
    endfunction : phase_len

    // ------------------------------------------------------------------
    // Sequencer and shift logic
    // ------------------------------------------------------------------
    seq_state_t            state_reg, state_next;
    logic [9:0]            cnt_reg, cnt_next, h_cyc, l_cyc;
    logic [7:0]            div_reg, div_next;
    logic [5:0]            len_reg, len_next, tx_cnt_reg, tx_cnt_next;
    logic [5:0]            rx_cnt_reg, rx_cnt_next;
    logic [WORD_MAX-1:0]   tx_sh_reg, tx_sh_next, rx_sh_reg, rx_sh_next;
    logic [WORD_MAX-1:0]   rx_word_next, loaded;
    logic                  clk_reg, clk_next, sel_reg, sel_next;
    logic                  dout_reg, dout_next, doe_reg, doe_next, rx_valid_next;
    logic [`SAMPLE_DELAY_CYC-1:0] samp_reg, samp_next;
    mode_t                 mode_next;
    logic                  unsup_next, tx_sel, rx_sel, tx_sel_on, clk_rise, strobe;

    always_comb begin
        h_cyc      = phase_len(div_reg, 1'b1);
        l_cyc      = phase_len(div_reg, 1'b0);
        tx_sel     = ~stable_reg[`PIN_TX_SYNC];                       // R7
        rx_sel     = ~stable_reg[`PIN_RX_SYNC];                       // R7
        tx_sel_on  = tx_sel & stable_d_reg[`PIN_TX_SYNC];
        clk_rise   = stable_reg[`PIN_CLK] & ~stable_d_reg[`PIN_CLK];
        loaded     = (tx_word << (WORD_MAX - 1 - int'(cfg.word_len)));
        tx_ready   = cfg.master_en ? (state_reg == st_idle) : tx_sel_on;
        state_next = state_reg;
        cnt_next   = cnt_reg;
        div_next   = div_reg;
        len_next   = len_reg;
        tx_cnt_next = tx_cnt_reg;
        rx_cnt_next = rx_cnt_reg;
        tx_sh_next = tx_sh_reg;
        rx_sh_next = rx_sh_reg;
        rx_word_next = rx_word;
        clk_next   = clk_reg;
        sel_next   = sel_reg;
        dout_next  = dout_reg;
        doe_next   = doe_reg;
        rx_valid_next = 1'b0;
        samp_next  = {samp_reg[`SAMPLE_DELAY_CYC-2:0], 1'b0};
        strobe     = 1'b0;
        // Mode bits follow the role; source and polarities are fixed.
        mode_next.rate_clock_source_sel = `SOURCE_SEL_CPU;            // R2
        mode_next.rate_clock_divider    = cfg.master_en ? cfg.rate_clock_divider
                                                        : `SLAVE_DIVIDER; // R1
        mode_next.tx_sync_polarity      = `SYNC_POL_INVERT;           // R6
        mode_next.rx_sync_polarity      = `SYNC_POL_INVERT;           // R6
        mode_next.tx_clock_dir_mode = cfg.master_en ? `DIR_INTERNAL : `DIR_EXTERNAL; // R8 R9
        mode_next.rx_clock_dir_mode = `DIR_EXTERNAL;                  // R8 R9
        mode_next.tx_sync_dir_mode  = cfg.master_en ? `DIR_INTERNAL : `DIR_EXTERNAL; // R8 R9
        mode_next.rx_sync_dir_mode  = `DIR_EXTERNAL;                  // R8 R9
        unsup_next = (cfg.clock_stop_mode != `CLOCK_STOP_DELAYED) ||
                     (cfg.tx_clock_polarity != `CLOCK_POL_IDLE_HIGH);
        if (cfg.master_en) begin
            if (cnt_reg != 10'h000) begin
                cnt_next = cnt_reg - 10'h001;
            end
            case (state_reg)
                st_idle: begin
                    clk_next = `CLOCK_POL_IDLE_HIGH;                  // R15
                    sel_next = 1'b1;                                  // R15
                    doe_next = 1'b0;
                    if (tx_valid) begin
                        div_next    = cfg.rate_clock_divider;
                        len_next    = cfg.word_len;
                        tx_cnt_next = cfg.word_len;
                        tx_sh_next  = loaded;
                        sel_next    = 1'b0;                           // R6 R10
                        cnt_next    = phase_len(cfg.rate_clock_divider, 1'b0) - 10'h001;
                        state_next  = st_lead;
                    end
                end
                st_lead: begin
                    // First bit appears one low phase after select falls.
                    if (cnt_reg == 10'h000) begin
                        dout_next  = tx_sh_reg[WORD_MAX-1];           // R12
                        doe_next   = 1'b1;
                        cnt_next   = h_cyc - 10'h001;
                        state_next = st_first;
                    end
                end
                st_first: begin
                    // Clock first falls one full period after select.
                    if (cnt_reg == 10'h000) begin
                        clk_next   = 1'b0;                            // R12 R3
                        cnt_next   = l_cyc - 10'h001;
                        state_next = st_low;
                    end
                end
                st_low: begin
                    if (cnt_reg == 10'h000) begin
                        clk_next  = 1'b1;                             // R5 R10
                        samp_next[0] = 1'b1;                          // R11
                        cnt_next  = h_cyc - 10'h001;
                        if (tx_cnt_reg == 6'h00) begin
                            doe_next   = 1'b0;                        // R14
                            state_next = st_tail;
                        end else begin
                            tx_sh_next  = {tx_sh_reg[WORD_MAX-2:0], 1'b0};
                            dout_next   = tx_sh_reg[WORD_MAX-2];      // R11
                            tx_cnt_next = tx_cnt_reg - 6'h01;
                            state_next  = st_high;
                        end
                    end
                end
                st_high: begin
                    if (cnt_reg == 10'h000) begin
                        clk_next   = 1'b0;                            // R4 R3
                        cnt_next   = l_cyc - 10'h001;
                        state_next = st_low;
                    end
                end
                st_tail: begin
                    // Select stays low one high phase past the last rise.
                    if (cnt_reg == 10'h000) begin
                        sel_next   = 1'b1;                            // R13 R15
                        state_next = st_idle;
                    end
                end
                default: begin
                    state_next = st_idle;
                end
            endcase
            strobe = samp_reg[`SAMPLE_DELAY_CYC-1];                   // R11
        end else begin
            // Slave: clock and select come from the pins.
            state_next = st_idle;
            clk_next   = `CLOCK_POL_IDLE_HIGH;
            sel_next   = 1'b1;
            len_next   = cfg.word_len;
            doe_next   = tx_sel;                                      // R7 R9
            if (tx_sel_on) begin
                tx_sh_next = tx_valid ? loaded : '0;
                dout_next  = tx_valid ? loaded[WORD_MAX-1] : 1'b0;
            end else if (tx_sel && clk_rise) begin
                tx_sh_next = {tx_sh_reg[WORD_MAX-2:0], 1'b0};
                dout_next  = tx_sh_reg[WORD_MAX-2];                   // R11
            end
            strobe = rx_sel & clk_rise;                               // R11
            if (!rx_sel) begin
                rx_cnt_next = 6'h00;
            end
        end
        // Receive: every strobe takes one bit, the word ends after len plus one bits.
        if (strobe) begin
            rx_sh_next = {rx_sh_reg[WORD_MAX-2:0], stable_reg[`PIN_DATA]};
            if (rx_cnt_reg == len_reg) begin
                rx_cnt_next   = 6'h00;
                rx_valid_next = 1'b1;
                rx_word_next  = {rx_sh_reg[WORD_MAX-2:0], stable_reg[`PIN_DATA]} &
                                ({WORD_MAX{1'b1}} >> (WORD_MAX - 1 - int'(len_reg)));
            end else begin
                rx_cnt_next = rx_cnt_reg + 6'h01;
            end
        end
    end

    // Registers of the sequencer, the shifters and the mode report.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_reg       <= st_idle;
            cnt_reg         <= 10'h000;
            div_reg         <= 8'h00;
            len_reg         <= 6'h00;
            tx_cnt_reg      <= 6'h00;
            rx_cnt_reg      <= 6'h00;
            tx_sh_reg       <= '0;
            rx_sh_reg       <= '0;
            rx_word         <= '0;
            rx_valid        <= 1'b0;
            clk_reg         <= 1'b1;
            sel_reg         <= 1'b1;
            dout_reg        <= 1'b0;
            doe_reg         <= 1'b0;
            samp_reg        <= '0;
            mode            <= '0;
            cfg_unsupported <= 1'b0;
        end else begin
            state_reg       <= state_next;
            cnt_reg         <= cnt_next;
            div_reg         <= div_next;
            len_reg         <= len_next;
            tx_cnt_reg      <= tx_cnt_next;
            rx_cnt_reg      <= rx_cnt_next;
            tx_sh_reg       <= tx_sh_next;
            rx_sh_reg       <= rx_sh_next;
            rx_word         <= rx_word_next;
            rx_valid        <= rx_valid_next;
            clk_reg         <= clk_next;
            sel_reg         <= sel_next;
            dout_reg        <= dout_next;
            doe_reg         <= doe_next;
            samp_reg        <= samp_next;
            mode            <= mode_next;
            cfg_unsupported <= unsup_next;
        end
    end

    // Pin drive: clock and select are driven only as master.
    assign transmit_bit_clock_o   = clk_reg;
    assign transmit_bit_clock_oe  = mode.tx_clock_dir_mode;           // R8 R9
    assign transmit_frame_sync_o  = sel_reg;
    assign transmit_frame_sync_oe = mode.tx_sync_dir_mode;            // R8 R9
    assign serial_data_out        = dout_reg;
    assign serial_data_out_oe     = doe_reg;
    assign busy                   = (state_reg != st_idle);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic [9:0] hi_cnt_reg, lo_cnt_reg;

    // Helper counters of the high and low time of the driven clock.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            hi_cnt_reg <= 10'h000;
            lo_cnt_reg <= 10'h000;
        end else begin
            hi_cnt_reg <= clk_reg ? 10'(hi_cnt_reg + 10'h001) : 10'h000;
            lo_cnt_reg <= clk_reg ? 10'h000 : 10'(lo_cnt_reg + 10'h001);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence s_lead_done;
        cfg.master_en && state_reg == st_lead && cnt_reg == 10'h000;
    endsequence

    sequence s_first_bit;
        ##1 (state_reg == st_first && serial_data_out_oe);
    endsequence

    a_slave_rate_quarter: assert property (!cfg.master_en ##1 1 |->       // R1
        mode.rate_clock_divider == `SLAVE_DIVIDER)
        else $error("slave divider not one");
    a_source_sel_cpu: assert property ($past(rstn) |->                    // R2
        mode.rate_clock_source_sel == `SOURCE_SEL_CPU)
        else $error("rate clock source not cpu");
    a_period_sum: assert property (busy |->                               // R3
        int'(h_cyc) + int'(l_cyc) == (int'(div_reg) + 1) * `RATE_UNIT_CYC)
        else $error("bit clock period wrong");
    a_high_phase: assert property ($fell(clk_reg) && $past(state_reg) == st_high |-> // R4
        hi_cnt_reg == h_cyc && lo_cnt_reg == 10'h000)
        else $error("high phase wrong");
    a_low_phase: assert property (cfg.master_en && $rose(clk_reg) && busy |-> // R5
        lo_cnt_reg == l_cyc && hi_cnt_reg == 10'h000)
        else $error("low phase wrong");
    a_sync_polarity: assert property ($past(rstn) |->                     // R6
        mode.tx_sync_polarity && mode.rx_sync_polarity)
        else $error("sync polarity not inverted");
    a_slave_select: assert property (!cfg.master_en ##1 !cfg.master_en |-> // R7
        serial_data_out_oe == ~$past(stable_reg[`PIN_TX_SYNC]))
        else $error("slave select not inverted");
    a_master_dirs: assert property (cfg.master_en ##1 1 |->               // R8
        mode.tx_clock_dir_mode && mode.tx_sync_dir_mode &&
        !mode.rx_clock_dir_mode && !mode.rx_sync_dir_mode)
        else $error("master direction bits wrong");
    a_slave_dirs: assert property (!cfg.master_en ##1 1 |->               // R9
        !mode.tx_clock_dir_mode && !mode.tx_sync_dir_mode &&
        !mode.rx_clock_dir_mode && !mode.rx_sync_dir_mode)
        else $error("slave direction bits wrong");
    a_select_first: assert property (cfg.master_en && $fell(clk_reg) |->  // R10
        !sel_reg)
        else $error("clock fell with select high");
    a_launch_rise: assert property (cfg.master_en && $changed(dout_reg) &&
        $past(state_reg) != st_lead |-> $rose(clk_reg))                   // R11
        else $error("data launched off rising edge");
    a_lead_data: assert property (s_lead_done |-> s_first_bit) // R12
        else $error("first bit not after low phase");
    a_tail_hold: assert property (cfg.master_en && $rose(sel_reg) |->     // R13
        hi_cnt_reg == h_cyc)
        else $error("select hold after last rise wrong");
    a_data_release: assert property (state_reg == st_tail |->             // R14
        !serial_data_out_oe)
        else $error("data pin driven in tail");
    a_idle_levels: assert property (cfg.master_en && state_reg == st_idle
        ##1 state_reg == st_idle |-> clk_reg && sel_reg)                  // R15
        else $error("idle master levels wrong");

endmodule : serial_port_spi_clock_stop

// ---- serial_port_spi_clock_stop_map.svh ----
`ifndef SERIAL_PORT_SPI_CLOCK_STOP_MAP_SVH
`define SERIAL_PORT_SPI_CLOCK_STOP_MAP_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
// Period of the CPU clock that serves as rate reference, in ns.
`define CPU_PERIOD_NS        10
// Period of ref_clk, in ns.
`define REF_PERIOD_NS        10
// Cycles of ref_clk in one rate unit of four CPU periods.
`define RATE_UNIT_CYC        ((4 * `CPU_PERIOD_NS) / `REF_PERIOD_NS)
// Strobe delay that lines up a master sample with the synchronised data.
`define SAMPLE_DELAY_CYC     4

// ----------------------------------------------------------------------
// Fixed configuration values
// ----------------------------------------------------------------------
`define SOURCE_SEL_CPU       1'b1
`define SLAVE_DIVIDER        8'h01
`define SYNC_POL_INVERT      1'b1
`define CLOCK_STOP_DELAYED   2'b11
`define CLOCK_POL_IDLE_HIGH  1'b1
`define DIR_EXTERNAL         1'b0
`define DIR_INTERNAL         1'b1

// ----------------------------------------------------------------------
// Pin index in the synchroniser vector
// ----------------------------------------------------------------------
`define PIN_CLK              0
`define PIN_TX_SYNC          1
`define PIN_RX_SYNC          2
`define PIN_DATA             3
`define PIN_COUNT            4

`endif

// ---- serial_port_spi_clock_stop_pkg.sv ----
package serial_port_spi_clock_stop_pkg;

    // Master sequencer states; one bit changes per step except into and out of st_tail.
    typedef enum logic [2:0] {
        st_idle  = 3'b000,
        st_lead  = 3'b001,
        st_first = 3'b011,
        st_low   = 3'b010,
        st_high  = 3'b110,
        st_tail  = 3'b111
    } seq_state_t;

    // Software configuration of the port.
    typedef struct packed {
        logic       master_en;          // 1 = master, 0 = slave.
        logic [1:0] clock_stop_mode;    // Only the delayed clock-stop mode is served.
        logic       tx_clock_polarity;  // Only idle-high polarity is served.
        logic [7:0] rate_clock_divider; // Divider used as master.
        logic [5:0] word_len;           // Bits per word minus one.
    } cfg_t;

    // Mode bits that the port applies, reported back to software.
    typedef struct packed {
        logic       rate_clock_source_sel;
        logic [7:0] rate_clock_divider;
        logic       tx_sync_polarity;
        logic       rx_sync_polarity;
        logic       tx_clock_dir_mode;
        logic       rx_clock_dir_mode;
        logic       tx_sync_dir_mode;
        logic       rx_sync_dir_mode;
    } mode_t;

endpackage : serial_port_spi_clock_stop_pkg

// ---- spi_slave_model.sv ----
`timescale 1ns/1ns

module spi_slave_model (
    input  wire logic       sclk,     // Bit clock from the master.
    input  wire logic       sel_n,    // Active-low select from the master.
    input  wire logic       mosi,     // Data from the master.
    input  wire logic [7:0] word,     // Word to return.
    output logic            miso,     // Data to the master.
    output logic [7:0]      got       // Word captured from the master.
);
    logic [7:0] sh;
    logic       mosi_q;

    // Loads the word when selected and shows its first bit before the first rising edge.
    initial miso = 1'b0;
    always @(negedge sel_n) begin
        sh = word;
        miso = sh[7];
    end
    // Keeps the low-phase data level, which the master holds up to the rising edge.
    always @(negedge sclk) mosi_q = mosi;
    // Samples on the rising edge and launches the next bit after a hold time.
    always @(posedge sclk) begin
        if (!sel_n) begin
            got = {got[6:0], mosi_q};
            #20;
            sh = {sh[6:0], ~sh[7]};
            miso = sh[7];
        end
    end
    // A released line shows the inverse level so a stale value cannot pass.
    always @(posedge sel_n) miso = ~miso;
endmodule : spi_slave_model

// ---- tb.sv ----
`timescale 1ns/1ns

module tb;
    import serial_port_spi_clock_stop_pkg::*;
    logic ref_clk, rstn, tx_valid, tx_ready, rx_valid, busy, unsup;
    logic clk_o, clk_oe, sync_o, sync_oe, dout, dout_oe, miso, ext_clk, ext_sel;
    logic [31:0] tx_word, rx_word;
    logic [7:0]  slv_word, got;
    cfg_t        cfg;
    mode_t       mode;
    int          fail_count, compares;

    // Clock and pin wiring; idle pins read high.
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    wire logic clk_pin  = clk_oe ? clk_o : ext_clk;
    wire logic sync_pin = sync_oe ? sync_o : ext_sel;

    serial_port_spi_clock_stop u_dut (.ref_clk(ref_clk), .rstn(rstn), .cfg(cfg),
        .cfg_unsupported(unsup), .mode(mode), .tx_word(tx_word), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_word(rx_word), .rx_valid(rx_valid), .busy(busy),
        .transmit_bit_clock_i(clk_pin), .transmit_bit_clock_o(clk_o),
        .transmit_bit_clock_oe(clk_oe), .transmit_frame_sync_i(sync_pin),
        .transmit_frame_sync_o(sync_o), .transmit_frame_sync_oe(sync_oe),
        .receive_frame_sync_i(sync_pin), .serial_data_out(dout), .serial_data_out_oe(dout_oe),
        .serial_data_in(miso));
    spi_slave_model u_slave (.sclk(clk_pin), .sel_n(sync_pin), .mosi(dout),
        .word(slv_word), .miso(miso), .got(got));

    task automatic chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : chk

    task automatic end_of_test;
        if (fail_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test

    // Checks the applied mode bits for slave and then master operation.
    task automatic mode_check;
        cfg.master_en = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk(mode === {1'b1, 8'h01, 6'b11_0000}, "slave mode bits");
        cfg.master_en = 1'b1;
        cfg.clock_stop_mode = 2'b10;
        repeat (2) @(negedge ref_clk);
        chk(unsup === 1'b1, "unsupported mode not flagged");
        cfg.clock_stop_mode = 2'b11;
        repeat (2) @(negedge ref_clk);
        chk(!unsup && mode === {1'b1, cfg.rate_clock_divider, 6'b11_1010}, "master mode");
    endtask : mode_check

    // Exchanges one 8-bit word as slave under a clock and select made by the bench.
    task automatic slave_xfer(input logic [7:0] txw, input logic [7:0] sw);
        int n;
        logic took, seen;
        {cfg.master_en, tx_valid, took, seen} = 4'b0100;
        tx_word = {24'h00_0000, txw};
        slv_word = sw;
        repeat (4) @(negedge ref_clk);
        ext_sel = 1'b0;
        for (n = 0; n < 136; n++) begin
            @(negedge ref_clk);
            ext_clk = ~n[3];
            took |= tx_ready === 1'b1;
            seen |= rx_valid === 1'b1;
        end
        ext_sel = 1'b1;
        repeat (8) @(negedge ref_clk);
        chk(took && seen, "slave handshake missing");
        chk(rx_word === {24'h00_0000, sw} && got === txw, "slave word swap");
        chk(dout_oe === 1'b0 && clk_oe === 1'b0 && sync_oe === 1'b0, "slave pins driven");
        {cfg.master_en, tx_valid} = 2'b10;
    endtask : slave_xfer

    // Sends one 8-bit word as master and measures the clock phases and the word swap.
    task automatic xfer(input logic [7:0] d, input logic [7:0] txw, input logic [7:0] sw);
        int n, lo, hi, falls, run, eh, el;
        logic prev, seen;
        eh = d[0] || d == 0 ? 2 * (d + 1) : 2 * d + 4;
        el = d[0] || d == 0 ? 2 * (d + 1) : 2 * d;
        cfg.rate_clock_divider = d;
        tx_word = {24'h00_0000, txw};
        slv_word = sw;
        tx_valid = 1'b1;
        chk(tx_ready === 1'b1, "not ready while idle");
        @(negedge ref_clk);
        chk(!tx_ready && busy && sync_o === 1'b0, "word not taken");
        tx_valid = 1'b0;
        {prev, seen, run, falls, lo, hi} = {2'b10, 128'd0};
        for (n = 0; n < 3000 && !seen; n++) begin
            @(negedge ref_clk);
            seen = rx_valid === 1'b1;
            if (clk_o !== prev) begin
                if (prev) chk(sync_o === 1'b0, "select not low at falling clock");
                if (prev) falls++;
                if (prev && falls > 1) hi = run;
                if (!prev) lo = run;
                run = 0;
            end
            run++;
            prev = clk_o;
        end
        chk(seen, "no receive pulse");
        if (!seen) end_of_test();
        chk(falls == 8 && lo == el && hi == eh, "clock count or phase width");
        chk(rx_word === {24'h00_0000, sw} && got === txw, "word swap");
        repeat (2 * eh + 4) @(negedge ref_clk);
        chk(!busy && clk_o === 1'b1 && sync_o === 1'b1 && dout_oe === 1'b0, "idle");
    endtask : xfer

    // Main sequence.
    initial begin
        {fail_count, compares} = 64'd0;
        {rstn, tx_valid, tx_word, slv_word} = 42'd0;
        {ext_clk, ext_sel} = 2'b11;
        cfg = '{1'b1, 2'b11, 1'b1, 8'h01, 6'h07};
        repeat (2) @(negedge ref_clk);
        rstn = 1'b1;
        chk(clk_o === 1'b1 && sync_o === 1'b1 && dout_oe === 1'b0, "reset idle");
        mode_check();
        xfer(8'h00, 8'hA5, 8'h3C);
        xfer(8'h01, 8'h81, 8'hC3);
        xfer(8'h02, 8'h5A, 8'h96);
        xfer(8'h03, 8'hFF, 8'h01);
        slave_xfer(8'h6C, 8'hB7);
        end_of_test();
    end
endmodule : tb
